// File: core/fbwp_pkg.sv
/*
 * Constants, types and the protection decode shared by the flash block write-protect logic.
 * Assumes a 24-bit byte address space split into 64 KB protection blocks.
 */
`default_nettype none

package fbwp_pkg;

	// Register bus map
	localparam int           APB_AW        = 8;
	localparam logic [7:0]   OFS_STATUS    = 8'h00;
	localparam logic [7:0]   OFS_FUNC      = 8'h04;
	localparam logic [7:0]   OFS_CTRL      = 8'h08;
	localparam logic [7:0]   OFS_RESULT    = 8'h0c;

	// Status and function byte layout
	localparam int           SR_WEL_BIT    = 1;
	localparam int           SR_BP_LSB     = 2;
	localparam int           SR_QE_BIT     = 6;
	localparam int           SR_SWD_BIT    = 7;
	localparam int           FR_TBS_BIT    = 1;

	// Control and result layout
	localparam int           CTRL_DENS_LSB = 0;
	localparam int           RES_GRANT_BIT = 0;
	localparam int           RES_CODE_LSB  = 4;
	localparam int           RES_CNT_LSB   = 16;

	// Density variants and reset values
	localparam logic [1:0]   DENS_256      = 2'h0;
	localparam logic [1:0]   DENS_128      = 2'h1;
	localparam logic [1:0]   DENS_64       = 2'h2;
	localparam logic [3:0]   LG_256        = 4'h8;
	localparam logic [3:0]   LG_128        = 4'h7;
	localparam logic [3:0]   LG_64         = 4'h6;
	localparam logic [1:0]   CTRL_RESET    = 2'h0;
	localparam logic         NV_RESET      = 1'b0;

	// Address geometry
	localparam int           FLASH_AW      = 24;
	localparam int           BLK_LSB       = 16;
	localparam int           BLK_W         = 8;

	typedef enum logic [2:0] {
		FBWP_CMD_NOP        = 3'h0,
		FBWP_CMD_WRITE_ENABLE_COMMAND       = 3'h1,
		FBWP_CMD_WRDI       = 3'h2,
		FBWP_CMD_WRITE_STATUS_COMMAND       = 3'h3,
		FBWP_CMD_PROG       = 3'h4,
		FBWP_CMD_ERASE      = 3'h5,
		FBWP_CMD_CHIP_ERASE = 3'h6,
		FBWP_CMD_SET_TBS    = 3'h7
	} fbwp_cmd_t;

	typedef enum logic [1:0] {
		FBWP_ST_IDLE = 2'b00,
		FBWP_ST_EVAL = 2'b01,
		FBWP_ST_ACK  = 2'b11
	} fbwp_state_t;

	// Block hit test for the selected density, code and end
	function automatic logic fbwp_prot_hit(input logic [BLK_W-1:0] blk, input logic [3:0] code,
		input logic top_bottom_select, input logic [1:0] dens);
		logic [3:0] lg;
		logic [8:0] nblk;
		logic [8:0] cnt;
		logic [8:0] b;
		begin
			case (dens)
				DENS_128: lg = LG_128;
				DENS_64:  lg = LG_64;
				default:  lg = LG_256;
			endcase
			nblk = 9'h001 << lg;
			b = {1'b0, blk} & (nblk - 9'h001);
			if (code == 4'h0)
				cnt = 9'h000;
			else if (code > lg)
				cnt = nblk;
			else
				cnt = 9'h001 << (code - 4'h1);
			fbwp_prot_hit = top_bottom_select ? (b < cnt) : (b >= nblk - cnt);
		end
	endfunction

endpackage

`default_nettype wire

// File: core/fbwp_top.sv
/*
 * Flash block write-protect logic: status and top/bottom bits, command gating,
 * pin function selection, and an APB register view.
 * Assumes decoded commands arrive on the serial-clock side and APB runs on clk.
 */
// Our own choices: the APB interface to the registers and the address map.
`default_nettype none

module fbwp_top
	import fbwp_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire logic [APB_AW-1:0]    paddr,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 lnk_clk,
	input  wire logic                 lnk_cmd_valid,
	input  wire logic [2:0]           lnk_cmd_code,
	input  wire logic [FLASH_AW-1:0]  lnk_cmd_addr,
	input  wire logic [7:0]           lnk_cmd_data,
	output logic                      lnk_busy,
	output logic                      lnk_done,
	output logic                      lnk_granted,
	input  wire logic [1:0]           lnk_lane_dout,
	input  wire logic                 lnk_lane_oe,
	output logic      [1:0]           lnk_lane_din,
	output logic                      lnk_hold,
	input  wire logic                 wp_lane2_pin_i,
	input  wire logic                 hold_lane3_pin_i,
	output logic                      data_lane_2_o,
	output logic                      data_lane_2_oe,
	output logic                      data_lane_3_o,
	output logic                      data_lane_3_oe
);

	// Status and function bits
	logic        wel_q;
	logic [3:0]  bp_q;
	logic        qe_q;
	logic        swd_q;
	logic        tbs_q;
	logic [1:0]  dens_q;

	// Link-side request holding registers
	logic        req_tgl_l_q;
	fbwp_cmd_t   code_l_q;
	logic [FLASH_AW-1:0] addr_l_q;
	logic [7:0]  data_l_q;
	logic        ack_s1_l_q;
	logic        ack_s2_l_q;
	logic        ack_s3_l_q;
	logic        ack_edge_l;

	// System-side handshake and result
	logic        req_s1_q;
	logic        req_s2_q;
	logic        req_s3_q;
	logic        req_edge;
	logic        ack_tgl_q;
	fbwp_state_t state_q;
	fbwp_cmd_t   cmd_q;
	logic [FLASH_AW-1:0] addr_q;
	logic [7:0]  data_q;
	logic        grant_q;
	logic [15:0] refuse_cnt_q;

	// Pin synchronisers and cross-domain levels
	logic        wp_s1_q;
	logic        wp_s2_q;
	logic        qe_s1_l_q;
	logic        qe_s2_l_q;
	logic [1:0]  lane_s1_l_q;
	logic [1:0]  lane_s2_l_q;

	logic        apb_acc;
	logic        sr_write_ok;
	logic        blk_hit;
	logic        grant_d;
	logic [31:0] rdata_d;
	logic        map_hit;
	logic        eval_now;

	// Field widths inside the status, control and result views
	localparam int              BP_W    = 4;
	localparam int              CMD_W   = 3;
	localparam int              CNT_W   = 16;
	localparam int              DENS_W  = 2;
	localparam logic [BP_W-1:0] BP_NONE = 4'h0;

	// Link domain: take a command and hold it until the answer returns
	// A command offered while busy is dropped; the host waits for done
	always_ff @(posedge lnk_clk or negedge rstn) begin
		if (!rstn) begin
			req_tgl_l_q <= 1'b0;
			code_l_q    <= FBWP_CMD_NOP;
			addr_l_q    <= '0;
			data_l_q    <= 8'h00;
			lnk_busy    <= 1'b0;
		end else if (lnk_cmd_valid && !lnk_busy) begin
			req_tgl_l_q <= ~req_tgl_l_q;
			code_l_q    <= fbwp_cmd_t'(lnk_cmd_code);
			addr_l_q    <= lnk_cmd_addr;
			data_l_q    <= lnk_cmd_data;
			lnk_busy    <= 1'b1;
		end else if (ack_edge_l) begin
			lnk_busy    <= 1'b0;
		end
	end

	always_ff @(posedge lnk_clk or negedge rstn) begin
		if (!rstn) begin
			ack_s1_l_q <= 1'b0;
			ack_s2_l_q <= 1'b0;
			ack_s3_l_q <= 1'b0;
		end else begin
			ack_s1_l_q <= ack_tgl_q;
			ack_s2_l_q <= ack_s1_l_q;
			ack_s3_l_q <= ack_s2_l_q;
		end
	end

	assign ack_edge_l = ack_s2_l_q ^ ack_s3_l_q;

	// Grant is stable on the system side from before the ack toggle
	always_ff @(posedge lnk_clk or negedge rstn) begin
		if (!rstn) begin
			lnk_done    <= 1'b0;
			lnk_granted <= 1'b0;
		end else begin
			lnk_done <= ack_edge_l;
			if (ack_edge_l)
				lnk_granted <= grant_q;
		end
	end

	// Link domain pins; quad enable crosses as a level
	always_ff @(posedge lnk_clk or negedge rstn) begin
		if (!rstn) begin
			qe_s1_l_q   <= 1'b0;
			qe_s2_l_q   <= 1'b0;
			lane_s1_l_q <= 2'h0;
			lane_s2_l_q <= 2'h0;
		end else begin
			qe_s1_l_q   <= qe_q;
			qe_s2_l_q   <= qe_s1_l_q;
			lane_s1_l_q <= {hold_lane3_pin_i, wp_lane2_pin_i};
			lane_s2_l_q <= lane_s1_l_q;
		end
	end

	always_ff @(posedge lnk_clk or negedge rstn) begin
		if (!rstn) begin
			data_lane_2_o  <= 1'b0;
			data_lane_2_oe <= 1'b0;
			data_lane_3_o  <= 1'b0;
			data_lane_3_oe <= 1'b0;
			lnk_lane_din   <= 2'h0;
			lnk_hold       <= 1'b0;
		end else begin
			data_lane_2_o  <= qe_s2_l_q & lnk_lane_dout[0];
			data_lane_2_oe <= qe_s2_l_q & lnk_lane_oe;
			data_lane_3_o  <= qe_s2_l_q & lnk_lane_dout[1];
			data_lane_3_oe <= qe_s2_l_q & lnk_lane_oe;
			lnk_lane_din   <= qe_s2_l_q ? lane_s2_l_q : 2'h0;
			lnk_hold       <= ~qe_s2_l_q & ~lane_s2_l_q[1];
		end
	end

	// System side: request synchroniser
	// Protect pin passes two flops before the status write gate reads it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_s3_q <= 1'b0;
			wp_s1_q  <= 1'b0;
			wp_s2_q  <= 1'b0;
		end else begin
			req_s1_q <= req_tgl_l_q;
			req_s2_q <= req_s1_q;
			req_s3_q <= req_s2_q;
			wp_s1_q  <= wp_lane2_pin_i;
			wp_s2_q  <= wp_s1_q;
		end
	end

	assign req_edge = req_s2_q ^ req_s3_q;

	// Link holding registers are stable while the toggle is pending
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q   <= FBWP_ST_IDLE;
			cmd_q     <= FBWP_CMD_NOP;
			addr_q    <= '0;
			data_q    <= 8'h00;
			ack_tgl_q <= 1'b0;
		end else begin
			case (state_q)
				FBWP_ST_IDLE: begin
					if (req_edge) begin
						cmd_q   <= code_l_q;
						addr_q  <= addr_l_q;
						data_q  <= data_l_q;
						state_q <= FBWP_ST_EVAL;
					end
				end
				FBWP_ST_EVAL: begin
					state_q <= FBWP_ST_ACK;
				end
				FBWP_ST_ACK: begin
					ack_tgl_q <= ~ack_tgl_q;
					state_q   <= FBWP_ST_IDLE;
				end
				default: begin
					state_q <= FBWP_ST_IDLE;
				end
			endcase
		end
	end

	// One evaluation slot per command, so every update sees the same inputs
	assign eval_now = (state_q == FBWP_ST_EVAL);

	// Block index from the 64 KB granule
	// Code to block count per variant
	assign blk_hit = fbwp_prot_hit(addr_q[BLK_LSB +: BLK_W], bp_q, tbs_q, dens_q);

	// Quad mode removes the protect pin, so it counts as high there
	// Status write gate
	assign sr_write_ok = !swd_q || wp_s2_q || qe_q;

	always_comb begin
		grant_d = 1'b0;
		case (cmd_q)
			FBWP_CMD_WRITE_ENABLE_COMMAND:       grant_d = 1'b1;
			FBWP_CMD_WRDI:       grant_d = 1'b1;
			FBWP_CMD_WRITE_STATUS_COMMAND:       grant_d = wel_q && sr_write_ok;
			FBWP_CMD_SET_TBS:    grant_d = wel_q;
			FBWP_CMD_PROG:       grant_d = wel_q && !blk_hit;
			FBWP_CMD_ERASE:      grant_d = wel_q && !blk_hit;
			// Chip erase only with code zero
			FBWP_CMD_CHIP_ERASE: grant_d = wel_q && (bp_q == BP_NONE);
			default:             grant_d = 1'b0;
		endcase
	end

	// Judged once, on the values held at evaluation
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			grant_q      <= 1'b0;
			refuse_cnt_q <= 16'h0000;
		end else if (eval_now) begin
			grant_q <= grant_d;
			if (!grant_d)
				refuse_cnt_q <= refuse_cnt_q + 16'h0001;
		end
	end

	// Write enable latch clears after a granted write or on WRDI
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wel_q <= 1'b0;
		end else if (eval_now) begin
			case (cmd_q)
				FBWP_CMD_WRITE_ENABLE_COMMAND: wel_q <= 1'b1;
				FBWP_CMD_WRDI: wel_q <= 1'b0;
				FBWP_CMD_NOP:  wel_q <= wel_q;
				default:       wel_q <= grant_d ? 1'b0 : wel_q;
			endcase
		end
	end

	// Reset stands in for the factory zero of the retained cells
	// Retained status bits change only by status write
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bp_q  <= {4{NV_RESET}};
			qe_q  <= NV_RESET;
			swd_q <= NV_RESET;
		end else if (eval_now && cmd_q == FBWP_CMD_WRITE_STATUS_COMMAND && grant_d) begin
			bp_q  <= data_q[SR_BP_LSB +: BP_W];
			qe_q  <= data_q[SR_QE_BIT];
			swd_q <= data_q[SR_SWD_BIT];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tbs_q <= NV_RESET;
		end else if (eval_now && cmd_q == FBWP_CMD_SET_TBS && grant_d) begin
			tbs_q <= tbs_q | data_q[FR_TBS_BIT];
		end
	end

	// APB slave, one wait state on every access
	assign apb_acc = psel && penable && !pready;
	assign map_hit = (paddr == OFS_STATUS) || (paddr == OFS_FUNC) ||
		(paddr == OFS_CTRL) || (paddr == OFS_RESULT);

	always_comb begin
		rdata_d = 32'h0000_0000;
		case (paddr)
			OFS_STATUS: begin
				rdata_d[SR_WEL_BIT]       = wel_q;
				rdata_d[SR_BP_LSB +: BP_W] = bp_q;
				rdata_d[SR_QE_BIT]        = qe_q;
				rdata_d[SR_SWD_BIT]       = swd_q;
			end
			OFS_FUNC:   rdata_d[FR_TBS_BIT] = tbs_q;
			OFS_CTRL:   rdata_d[CTRL_DENS_LSB +: DENS_W] = dens_q;
			OFS_RESULT: begin
				rdata_d[RES_GRANT_BIT]     = grant_q;
				rdata_d[RES_CODE_LSB +: CMD_W] = cmd_q;
				rdata_d[RES_CNT_LSB +: CNT_W]  = refuse_cnt_q;
			end
			default:    rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= apb_acc;
			pslverr <= apb_acc && !map_hit;
			prdata  <= (apb_acc && !pwrite) ? rdata_d : 32'h0000_0000;
		end
	end

	// Density change mid-command would move the area; software sets it once
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dens_q <= CTRL_RESET;
		end else if (apb_acc && pwrite && paddr == OFS_CTRL && pstrb[0]) begin
			dens_q <= pwdata[CTRL_DENS_LSB +: DENS_W];
		end
	end

endmodule // fbwp_top

`default_nettype wire

// File: test/fbwp_host.sv
/* Host command model on the link. Assumes the bench calls wsend. */
`default_nettype none
module fbwp_host (
	input  wire logic        lnk_clk,
	output logic             lnk_cmd_valid,
	output logic [2:0]       lnk_cmd_code,
	output logic [23:0]      lnk_cmd_addr,
	output logic [7:0]       lnk_cmd_data,
	input  wire logic        lnk_busy,
	input  wire logic        lnk_done,
	input  wire logic        lnk_granted
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		lnk_cmd_valid = 1'b0;
		lnk_cmd_code  = 3'h0;
		lnk_cmd_addr  = 24'h000000;
		lnk_cmd_data  = 8'h00;
	end
	task automatic send(input logic [2:0] c, input logic [23:0] a, input logic [7:0] d, output logic g);
		@(posedge lnk_clk);
		while (lnk_busy) @(posedge lnk_clk);
		lnk_cmd_valid <= 1'b1;
		lnk_cmd_code  <= c;
		lnk_cmd_addr  <= a;
		lnk_cmd_data  <= d;
		@(posedge lnk_clk);
		// Stale address and data scrambled so nothing leans on them
		lnk_cmd_valid <= 1'b0;
		lnk_cmd_addr  <= ~a;
		lnk_cmd_data  <= ~d;
		// No limit here; the bench watchdog ends a hung wait
		do begin
			@(negedge lnk_clk);
		end while (lnk_done !== 1'b1);
		g = lnk_granted;
	endtask
	task automatic wsend(input logic [2:0] c, input logic [23:0] a, input logic [7:0] d, output logic g);
		send(3'h1, 24'h000000, 8'h00, g);
		send(c, a, d, g);
	endtask
endmodule // fbwp_host
`default_nettype wire

// File: test/fbwp_monitor.sv
/* Checker on the top ports. Assumes APB on clk, commands on lnk_clk. */
`default_nettype none
module fbwp_monitor (
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic       lnk_clk,
	input wire logic       lnk_cmd_valid,
	input wire logic       lnk_busy,
	input wire logic       lnk_done,
	input wire logic       lnk_granted,
	input wire logic       lnk_hold,
	input wire logic [1:0] lnk_lane_din,
	input wire logic       data_lane_2_oe,
	input wire logic       data_lane_3_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	a_apb_wait: assert property (@(posedge clk) disable iff (!rstn)
		psel && penable && !pready |=> pready) else $error("no apb answer");
	a_err_ready: assert property (@(posedge clk) disable iff (!rstn)
		pslverr |-> pready) else $error("slverr without ready");
	a_ready_pulse: assert property (@(posedge clk) disable iff (!rstn)
		pready |=> !pready) else $error("ready too long");
	a_take_busy: assert property (@(posedge lnk_clk) disable iff (!rstn)
		lnk_cmd_valid && !lnk_busy |=> lnk_busy) else $error("command not taken");
	a_done_bound: assert property (@(posedge lnk_clk) disable iff (!rstn)
		$rose(lnk_busy) |-> ##[1:12] lnk_done) else $error("no answer");
	a_done_frees: assert property (@(posedge lnk_clk) disable iff (!rstn)
		lnk_done |-> !lnk_busy ##1 !lnk_done) else $error("bad done pulse");
	a_grant_done: assert property (@(posedge lnk_clk) disable iff (!rstn)
		!$stable(lnk_granted) |-> lnk_done) else $error("grant moved alone");
	a_hold_quad: assert property (@(posedge lnk_clk) disable iff (!rstn)
		lnk_hold |-> !data_lane_2_oe && !data_lane_3_oe && lnk_lane_din == 2'h0)
		else $error("lanes active with hold");
	a_lane_pair: assert property (@(posedge lnk_clk) disable iff (!rstn)
		data_lane_2_oe |-> data_lane_3_oe) else $error("lane enables differ");
endmodule // fbwp_monitor
`default_nettype wire

// File: test/testbench.sv
/* Top bench: APB tasks, host model, protect table sweep. Assumes fbwp_top. */
`default_nettype none
module testbench import fbwp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, lnk_clk = 1'b0, rstn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0]  pstrb = 4'hf;
	logic        lnk_cmd_valid, lnk_busy, lnk_done, lnk_granted, lnk_hold, lnk_lane_oe = 1'b0;
	logic [2:0]  lnk_cmd_code;
	logic [23:0] lnk_cmd_addr;
	logic [7:0]  lnk_cmd_data;
	logic [1:0]  lnk_lane_dout = 2'h0, lnk_lane_din;
	logic        wp_lane2_pin_i = 1'b1, hold_lane3_pin_i = 1'b1;
	logic        data_lane_2_o, data_lane_2_oe, data_lane_3_o, data_lane_3_oe;
	int          fail_count = 0, checked = 0;
	always #4 clk = ~clk;
	initial begin
		#3;
		forever #24 lnk_clk = ~lnk_clk;
	end
	fbwp_top dut (.clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .lnk_clk, .lnk_cmd_valid, .lnk_cmd_code, .lnk_cmd_addr, .lnk_cmd_data, .lnk_busy,
		.lnk_done, .lnk_granted, .lnk_lane_dout, .lnk_lane_oe, .lnk_lane_din, .lnk_hold, .wp_lane2_pin_i,
		.hold_lane3_pin_i, .data_lane_2_o, .data_lane_2_oe, .data_lane_3_o, .data_lane_3_oe);
	fbwp_host host (.lnk_clk, .lnk_cmd_valid, .lnk_cmd_code, .lnk_cmd_addr, .lnk_cmd_data, .lnk_busy,
		.lnk_done, .lnk_granted);
	task automatic end_of_test();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk_bit(input logic g, input logic e);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %0t bit %b exp %b", $time, g, e);
		end
	endtask
	task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %0t word %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic hit(int b, int c, logic t, int lg);
		int n, k;
		n = 1 << lg;
		k = (c == 0) ? 0 : ((c > lg) ? n : (1 << (c - 1)));
		return t ? (b < k) : (b >= n - k);
	endfunction
	task automatic sweep(input logic t);
		int d, c, i, b, lg;
		logic g, e;
		logic [31:0] r;
		for (d = 0; d < 3; d++) begin
			lg = 8 - d;
			apb(1'b1, OFS_CTRL, 32'(d), r, e);
			for (c = 0; c < 16; c++) begin
				host.wsend(FBWP_CMD_WRITE_STATUS_COMMAND, 24'h0, {2'h0, 4'(c), 2'h0}, g);
				host.wsend(FBWP_CMD_CHIP_ERASE, 24'h0, 8'h00, g);
				chk_bit(g, c == 0);
				for (i = 0; i < 3; i++) begin
					b = (i == 0) ? 0 : ((i == 1) ? (1 << (lg - 1)) - 1 : (1 << lg) - 1);
					host.wsend(FBWP_CMD_ERASE, {8'(b), 16'h0}, 8'h00, g);
					chk_bit(g, !hit(b, c, t, lg));
				end
			end
		end
		$display("sweep %b done", t);
	endtask
	initial begin
		logic [31:0] r, q;
		logic g, e;
		int a;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge lnk_clk);
		for (a = 0; a < 5; a++) begin
			apb(1'b0, 8'(a * 4), 32'h0, r, e);
			chk_word(r, 32'h0);
			chk_bit(e, a == 4);
		end
		$display("reset values done");
		sweep(1'b0);
		host.wsend(FBWP_CMD_SET_TBS, 24'h0, 8'h02, g);
		sweep(1'b1);
		host.wsend(FBWP_CMD_SET_TBS, 24'h0, 8'h00, g);
		apb(1'b0, OFS_FUNC, 32'h0, r, e);
		chk_word(r, 32'h2);
		host.wsend(FBWP_CMD_WRITE_STATUS_COMMAND, 24'h0, 8'h80, g);
		chk_bit(g, 1'b1);
		@(posedge clk);
		wp_lane2_pin_i <= 1'b0;
		repeat (8) @(posedge lnk_clk);
		host.wsend(FBWP_CMD_WRITE_STATUS_COMMAND, 24'h0, 8'h04, g);
		chk_bit(g, 1'b0);
		apb(1'b0, OFS_STATUS, 32'h0, r, e);
		chk_word(r, 32'h82);
		wp_lane2_pin_i <= 1'b1;
		repeat (8) @(posedge lnk_clk);
		host.wsend(FBWP_CMD_WRITE_STATUS_COMMAND, 24'h0, 8'h00, g);
		chk_bit(g, 1'b1);
		@(posedge clk);
		wp_lane2_pin_i <= 1'b0;
		host.wsend(FBWP_CMD_WRITE_STATUS_COMMAND, 24'h0, 8'h40, g);
		chk_bit(g, 1'b1);
		@(posedge clk);
		lnk_lane_oe   <= 1'b1;
		lnk_lane_dout <= 2'h2;
		repeat (12) @(negedge lnk_clk);
		chk_bit(data_lane_2_oe, 1'b1);
		chk_word({data_lane_3_o, data_lane_2_o}, 32'h2);
		chk_word(lnk_lane_din, 32'h2);
		host.wsend(FBWP_CMD_WRITE_STATUS_COMMAND, 24'h0, 8'h00, g);
		@(posedge clk);
		hold_lane3_pin_i <= 1'b0;
		repeat (12) @(negedge lnk_clk);
		chk_bit(lnk_hold, 1'b1);
		chk_bit(data_lane_3_oe, 1'b0);
		$display("pin tests done");
		apb(1'b1, OFS_CTRL, 32'h3, r, e);
		host.wsend(FBWP_CMD_WRITE_STATUS_COMMAND, 24'h0, 8'h20, g);
		host.wsend(FBWP_CMD_PROG, 24'hc8_0000, 8'h00, g);
		chk_bit(g, 1'b1);
		apb(1'b0, OFS_RESULT, 32'h0, q, e);
		host.wsend(FBWP_CMD_PROG, 24'h7f_0000, 8'h00, g);
		chk_bit(g, 1'b0);
		apb(1'b0, OFS_RESULT, 32'h0, r, e);
		chk_word(r, {q[31:16] + 16'h0001, 9'h000, 3'h4, 4'h0});
		host.send(FBWP_CMD_WRDI, 24'h0, 8'h00, g);
		host.send(FBWP_CMD_PROG, 24'hc8_0000, 8'h00, g);
		chk_bit(g, 1'b0);
		$display("command tests done");
		end_of_test();
	end
	initial begin
		repeat (95000) @(posedge clk);
		fail_count++;
		end_of_test();
	end
endmodule // testbench
bind fbwp_top fbwp_monitor u_mon (.clk, .rstn, .psel, .penable, .pready, .pslverr, .lnk_clk, .lnk_cmd_valid,
	.lnk_busy, .lnk_done, .lnk_granted, .lnk_hold, .lnk_lane_din, .data_lane_2_oe, .data_lane_3_oe);
`default_nettype wire
